//--- hdl/sac_pkg.sv
// package: register map, field positions, reset values and pin map of the aux output control block
package sac_pkg;
  // register word addresses on the control port
  localparam logic [15:0] SAC_ADDR_MODE = 16'he0c8;
  localparam logic [15:0] SAC_ADDR_LOCK = 16'he0c9;
  localparam logic [15:0] SAC_ADDR_HOT = 16'he0ca;
  localparam logic [15:0] SAC_ADDR_ENSTAT = 16'he0cb;
  localparam logic [15:0] SAC_ADDR_LOL = 16'he0cc;
  localparam logic [15:0] SAC_ADDR_PINCTL = 16'he241;
  localparam int SAC_REG_W = 16;

  // enable mode field encodings and reset values
  localparam logic [1:0] SAC_MODE_OFF = 2'h0;
  localparam logic [1:0] SAC_MODE_ON = 2'h1;
  localparam logic [1:0] SAC_MODE_HOT = 2'h2;
  localparam logic [1:0] SAC_MODE_RST = 2'h1;
  localparam logic SAC_HOT_RST = 1'b0;
  localparam logic SAC_LOL_RST = 1'b0;
  localparam logic [2:0] SAC_PINCTL_RST = 3'h0;

  // field positions
  localparam int SAC_BIT_FLAG = 0;
  localparam int SAC_BIT_G1 = 0;
  localparam int SAC_BIT_G2 = 1;
  localparam int SAC_BIT_FMT = 2;

  // synchroniser lanes for inputs arriving from the receiver domain
  localparam int SAC_IN_BCLK = 0;
  localparam int SAC_IN_FCLK = 1;
  localparam int SAC_IN_DATA = 2;
  localparam int SAC_IN_LOCK = 3;
  localparam int SAC_IN_VFC = 4;
  localparam int SAC_IN_BS = 5;
  localparam int SAC_IN_CS = 6;
  localparam int SAC_IN_UD = 7;
  localparam int SAC_IN_VAL = 8;
  localparam int SAC_IN_W = 9;

  // multipurpose pin assignment
  localparam int SAC_PINS = 12;
  localparam int SAC_PIN_VAL = 4;
  localparam int SAC_PIN_UD = 5;
  localparam int SAC_PIN_CS = 6;
  localparam int SAC_PIN_BS = 7;
  localparam int SAC_PIN_VFC = 8;
  localparam int SAC_PIN_SD = 9;
  localparam int SAC_PIN_BC = 10;
  localparam int SAC_PIN_FC = 11;

  // tdm framing: 8 slots of 32 bits
  localparam int SAC_WORD_W = 32;
  localparam logic [2:0] SAC_SLOT_LEFT = 3'h0;
  localparam logic [2:0] SAC_SLOT_AUX = 3'h1;
  localparam logic [2:0] SAC_SLOT_RIGHT = 3'h4;
  localparam logic [7:0] SAC_CNT_RST = 8'h00;
  localparam logic [5:0] SAC_HALF_BITS = 6'h20;
  // aux slot bit positions, top seven bits of the slot
  localparam int SAC_AUX_BS = 31;
  localparam int SAC_AUX_CS_R = 30;
  localparam int SAC_AUX_CS_L = 29;
  localparam int SAC_AUX_UD_R = 28;
  localparam int SAC_AUX_UD_L = 27;
  localparam int SAC_AUX_VAL_R = 26;
  localparam int SAC_AUX_VAL_L = 25;
endpackage

//--- hdl/sac_aux_out.sv
// module: receiver aux output enable, lock handling, i2s/tdm formatting onto multipurpose pins
`timescale 1ns/100ps
module sac_aux_out (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic rx_bit_clk,
  input wire logic rx_frame_clk,
  input wire logic rx_data,
  input wire logic rx_lock,
  input wire logic rx_virt_frame_clk,
  input wire logic rx_block_start,
  input wire logic rx_chan_status,
  input wire logic rx_user_data,
  input wire logic rx_validity,
  input wire logic [11:0] gpio_out,
  input wire logic [11:0] gpio_oe,
  output logic [11:0] multipurpose_pin_out,
  output logic [11:0] multipurpose_pin_oe,
  output logic rx_enable,
  output logic sample_rate_converter_mute
);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchroniser: three stages, change accepted when stages two and three agree
  logic [8:0] sync1, sync2, sync3, filt, filt_prev;
  logic [8:0] next_filt;
  logic [8:0] rx_bus;

  assign rx_bus = {rx_validity, rx_user_data, rx_chan_status, rx_block_start, rx_virt_frame_clk,
                   rx_lock, rx_data, rx_frame_clk, rx_bit_clk};

  // a single stage glitch never reaches the edge detectors
  always_comb begin
    for (int i = 0; i < sac_pkg::SAC_IN_W; i++) begin
      next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
      sync3 <= 9'h000;
      filt <= 9'h000;
      filt_prev <= 9'h000;
    end else begin
      sync1 <= rx_bus;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      filt_prev <= filt;
    end
  end

  logic lock, lock_fall, bclk_rise, bclk_fall, fclk_fall, fclk_rise;
  assign lock = filt[sac_pkg::SAC_IN_LOCK];
  assign lock_fall = filt_prev[sac_pkg::SAC_IN_LOCK] & ~lock;
  assign bclk_rise = filt[sac_pkg::SAC_IN_BCLK] & ~filt_prev[sac_pkg::SAC_IN_BCLK];
  assign bclk_fall = filt_prev[sac_pkg::SAC_IN_BCLK] & ~filt[sac_pkg::SAC_IN_BCLK];
  assign fclk_fall = filt_prev[sac_pkg::SAC_IN_FCLK] & ~filt[sac_pkg::SAC_IN_FCLK];
  assign fclk_rise = filt[sac_pkg::SAC_IN_FCLK] & ~filt_prev[sac_pkg::SAC_IN_FCLK];

  ////////////////////////////////////////////////////////////////////////////////
  // control registers and output enable state
  logic [1:0] mode, next_mode;
  logic hot, next_hot;
  logic lol, next_lol;
  logic [2:0] pinctl, next_pinctl;
  logic aux_en, next_aux_en;
  logic [15:0] next_rdata;

  // hardware clear of hot enable beats a same-cycle software write
  always_comb begin
    next_mode = mode;
    next_hot = hot;
    next_lol = lol;
    next_pinctl = pinctl;
    next_rdata = reg_rdata;
    if (reg_wr) begin
      case (reg_addr)
        sac_pkg::SAC_ADDR_MODE: next_mode = reg_wdata[1:0];
        sac_pkg::SAC_ADDR_HOT: next_hot = reg_wdata[sac_pkg::SAC_BIT_FLAG];
        sac_pkg::SAC_ADDR_LOL: next_lol = reg_wdata[sac_pkg::SAC_BIT_FLAG];
        sac_pkg::SAC_ADDR_PINCTL: next_pinctl = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (lock_fall) begin
      next_hot = 1'b0;
    end
    case (mode)
      sac_pkg::SAC_MODE_OFF: next_aux_en = 1'b0;
      sac_pkg::SAC_MODE_ON: next_aux_en = 1'b1;
      sac_pkg::SAC_MODE_HOT: next_aux_en = hot & lock;
      default: next_aux_en = 1'b0;
    endcase
    if (reg_rd) begin
      case (reg_addr)
        sac_pkg::SAC_ADDR_MODE: next_rdata = {14'h0000, mode};
        sac_pkg::SAC_ADDR_LOCK: next_rdata = {15'h0000, lock};
        sac_pkg::SAC_ADDR_HOT: next_rdata = {15'h0000, hot};
        sac_pkg::SAC_ADDR_ENSTAT: next_rdata = {15'h0000, aux_en};
        sac_pkg::SAC_ADDR_LOL: next_rdata = {15'h0000, lol};
        sac_pkg::SAC_ADDR_PINCTL: next_rdata = {13'h0000, pinctl};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode <= sac_pkg::SAC_MODE_RST;
      hot <= sac_pkg::SAC_HOT_RST;
      lol <= sac_pkg::SAC_LOL_RST;
      pinctl <= sac_pkg::SAC_PINCTL_RST;
      aux_en <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      mode <= next_mode;
      hot <= next_hot;
      lol <= next_lol;
      pinctl <= next_pinctl;
      aux_en <= next_aux_en;
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture of audio words and aux bits per half frame, tdm slot counter
  logic [7:0] bit_cnt, next_bit_cnt;
  logic [5:0] half_cnt, next_half_cnt;
  logic [31:0] shreg, next_shreg, left_w, next_left_w, left_o, next_left_o, right_o, next_right_o;
  logic [5:0] aux_lr, next_aux_lr;
  logic aux_bs, next_aux_bs;
  logic [6:0] aux_o, next_aux_o;

  // first 32 bits of each half are taken, so 64 and 256 bit clock frames both work
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_half_cnt = half_cnt;
    next_shreg = shreg;
    next_left_w = left_w;
    next_left_o = left_o;
    next_right_o = right_o;
    next_aux_lr = aux_lr;
    next_aux_bs = aux_bs;
    next_aux_o = aux_o;
    if (bclk_fall) begin
      next_bit_cnt = bit_cnt + 8'h01; // advance on falls so each bit stands across the rising edge
    end
    if (bclk_rise && (half_cnt < sac_pkg::SAC_HALF_BITS)) begin
      next_shreg = {shreg[30:0], filt[sac_pkg::SAC_IN_DATA]};
      next_half_cnt = half_cnt + 6'h01;
    end
    if (fclk_rise) begin
      next_half_cnt = 6'h00;
      next_left_w = shreg;
      next_aux_lr[1] = filt[sac_pkg::SAC_IN_CS]; // right side status, user, validity
      next_aux_lr[3] = filt[sac_pkg::SAC_IN_UD];
      next_aux_lr[5] = filt[sac_pkg::SAC_IN_VAL];
    end
    // frame start: words and aux of the finished frame move out together
    if (fclk_fall) begin
      next_bit_cnt = sac_pkg::SAC_CNT_RST;
      next_half_cnt = 6'h00;
      next_left_o = left_w;
      next_right_o = shreg;
      next_aux_o = {aux_bs, aux_lr[1], aux_lr[0], aux_lr[3], aux_lr[2], aux_lr[5], aux_lr[4]};
      next_aux_bs = filt[sac_pkg::SAC_IN_BS];
      next_aux_lr[0] = filt[sac_pkg::SAC_IN_CS];
      next_aux_lr[2] = filt[sac_pkg::SAC_IN_UD];
      next_aux_lr[4] = filt[sac_pkg::SAC_IN_VAL];
    end
    if (!lock) begin
      next_left_o = 32'h00000000;
      next_right_o = 32'h00000000;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bit_cnt <= sac_pkg::SAC_CNT_RST;
      half_cnt <= 6'h00;
      shreg <= 32'h00000000;
      left_w <= 32'h00000000;
      left_o <= 32'h00000000;
      right_o <= 32'h00000000;
      aux_lr <= 6'h00;
      aux_bs <= 1'b0;
      aux_o <= 7'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      half_cnt <= next_half_cnt;
      shreg <= next_shreg;
      left_w <= next_left_w;
      left_o <= next_left_o;
      right_o <= next_right_o;
      aux_lr <= next_aux_lr;
      aux_bs <= next_aux_bs;
      aux_o <= next_aux_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial formatting and pin drive
  logic frame_run, tdm, g1_on, g2_on, tdm_bit, sd_bit, fc_bit;
  logic [31:0] aux_word;
  logic [4:0] bit_idx;
  logic [11:0] next_pin_out, next_pin_oe;
  logic next_rx_enable, next_mute;

  assign frame_run = lock | lol;
  assign tdm = pinctl[sac_pkg::SAC_BIT_FMT];
  assign g1_on = pinctl[sac_pkg::SAC_BIT_G1] & aux_en;
  assign g2_on = pinctl[sac_pkg::SAC_BIT_G2] & aux_en;
  assign aux_word = {aux_o, 25'h0000000};
  assign bit_idx = 5'h1f - bit_cnt[4:0];

  // slot select from the upper counter bits; unused slots stay at zero
  always_comb begin
    case (bit_cnt[7:5])
      sac_pkg::SAC_SLOT_LEFT: tdm_bit = left_o[bit_idx];
      sac_pkg::SAC_SLOT_AUX: tdm_bit = aux_word[bit_idx];
      sac_pkg::SAC_SLOT_RIGHT: tdm_bit = right_o[bit_idx];
      default: tdm_bit = 1'b0;
    endcase
    sd_bit = lock & (tdm ? tdm_bit : filt[sac_pkg::SAC_IN_DATA]);
    fc_bit = frame_run & (tdm ? (bit_cnt == sac_pkg::SAC_CNT_RST) : filt[sac_pkg::SAC_IN_FCLK]);
    next_pin_out = gpio_out;
    next_pin_oe = gpio_oe;
    if (g1_on) begin
      next_pin_out[sac_pkg::SAC_PIN_SD] = sd_bit;
      next_pin_out[sac_pkg::SAC_PIN_BC] = filt[sac_pkg::SAC_IN_BCLK];
      next_pin_out[sac_pkg::SAC_PIN_FC] = fc_bit;
      next_pin_oe[sac_pkg::SAC_PIN_FC:sac_pkg::SAC_PIN_SD] = 3'h7;
    end
    if (g2_on) begin
      next_pin_out[sac_pkg::SAC_PIN_VAL] = filt[sac_pkg::SAC_IN_VAL];
      next_pin_out[sac_pkg::SAC_PIN_UD] = filt[sac_pkg::SAC_IN_UD];
      next_pin_out[sac_pkg::SAC_PIN_CS] = filt[sac_pkg::SAC_IN_CS];
      next_pin_out[sac_pkg::SAC_PIN_BS] = filt[sac_pkg::SAC_IN_BS];
      next_pin_out[sac_pkg::SAC_PIN_VFC] = frame_run & filt[sac_pkg::SAC_IN_VFC];
      next_pin_oe[sac_pkg::SAC_PIN_VFC:sac_pkg::SAC_PIN_VAL] = 5'h1f;
    end
    next_rx_enable = frame_run;
    next_mute = ~frame_run;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      multipurpose_pin_out <= 12'h000;
      multipurpose_pin_oe <= 12'h000;
      rx_enable <= 1'b0;
      sample_rate_converter_mute <= 1'b1;
    end else begin
      multipurpose_pin_out <= next_pin_out;
      multipurpose_pin_oe <= next_pin_oe;
      rx_enable <= next_rx_enable;
      sample_rate_converter_mute <= next_mute;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_mode_fixed;
    (mode != sac_pkg::SAC_MODE_HOT) |=> (aux_en == (($past(mode)) == sac_pkg::SAC_MODE_ON));
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("fixed mode enable wrong");
  property p_hot_mode;
    (mode == sac_pkg::SAC_MODE_HOT) |=> (aux_en == ($past(hot) & $past(lock)));
  endproperty
  a_hot_mode: assert property (p_hot_mode) else $error("hot mode enable wrong");
  property p_hot_clear;
    (filt_prev[sac_pkg::SAC_IN_LOCK] && !lock) |=> !hot ##1 !aux_en || mode != sac_pkg::SAC_MODE_HOT;
  endproperty
  a_hot_clear: assert property (p_hot_clear) else $error("hot enable kept after lock loss");
  property p_lock_read;
    (reg_rd && reg_addr == sac_pkg::SAC_ADDR_LOCK) |=> (reg_rdata == {15'h0000, $past(lock)});
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock readback wrong");
  property p_en_read;
    (reg_rd && reg_addr == sac_pkg::SAC_ADDR_ENSTAT) |=> (reg_rdata[0] == $past(aux_en));
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable status readback wrong");
  property p_reserved;
    reg_rd |=> (reg_rdata[15:3] == 13'h0000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
  property p_fs_stop;
    (!lock && !lol && g1_on) |=> !multipurpose_pin_out[sac_pkg::SAC_PIN_FC];
  endproperty
  a_fs_stop: assert property (p_fs_stop) else $error("frame sync while unlocked");
  property p_mute;
    (!lock && !lol) [*2] |-> sample_rate_converter_mute && !rx_enable;
  endproperty
  a_mute: assert property (p_mute) else $error("converter not muted");
  property p_zero_data;
    (!lock && g1_on) |=> !multipurpose_pin_out[sac_pkg::SAC_PIN_SD];
  endproperty
  a_zero_data: assert property (p_zero_data) else $error("data not zero while unlocked");
  property p_group_off;
    !g1_on |=> (multipurpose_pin_oe[11:9] == $past(gpio_oe[11:9]));
  endproperty
  a_group_off: assert property (p_group_off) else $error("disabled group drives pins");
endmodule

//--- dv/sac_rx_model.sv
// receiver model: bit clock, frame clock, serial data, lock and aux levels
`timescale 1ns/100ps
module sac_rx_model #(
  parameter logic [31:0] LEFT_W = 32'hc3a5_0f69,
  parameter logic [31:0] RIGHT_W = 32'h5a3c_96f0
) (
  input wire logic tdm,
  input wire logic locked,
  output logic bit_clk,
  output logic frame_clk,
  output logic data,
  output logic lock,
  output logic vfc,
  output logic bs,
  output logic cs,
  output logic ud,
  output logic val
);
  int h;
  int i;
  int half;
  // aux levels held steady so left and right copies must agree
  assign lock = locked;
  assign vfc = frame_clk;
  assign bs = 1'h1;
  assign cs = 1'h0;
  assign ud = 1'h1;
  assign val = 1'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // free-running stream, frame starts on frame clock fall, data moves on bit clock fall
  initial begin
    bit_clk = 1'h0;
    frame_clk = 1'h1;
    data = 1'h0;
    forever begin
      half = tdm ? 128 : 32;
      for (h = 0; h < 2; h++) begin
        frame_clk = h[0];
        for (i = 0; i < half; i++) begin
          // past the word the line toggles so stale bits never look valid
          data = (i < 32) ? (h == 0 ? LEFT_W[31 - i] : RIGHT_W[31 - i]) : ~data;
          #80 bit_clk = 1'h1;
          #80 bit_clk = 1'h0;
        end
      end
    end
  end
endmodule

//--- dv/sac_aux_out_bench.sv
// testbench: registers, pin routing, hot enable, loss of lock, i2s and tdm framing
`timescale 1ns/100ps
module sac_aux_out_bench;
  localparam logic [31:0] LW = 32'hc3a5_0f69;
  localparam logic [31:0] RW = 32'h5a3c_96f0;
  logic mclk, reset, reg_wr, reg_rd, tdm, locked, rx_enable, src_mute;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [11:0] gpio_out, gpio_oe, pin_out, pin_oe;
  logic rx_bclk, rx_fclk, rx_data, rx_lock, rx_vfc, rx_bs, rx_cs, rx_ud, rx_val;
  int failures, samples_checked;

  // device and receiver model
  sac_aux_out dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_bit_clk(rx_bclk), .rx_frame_clk(rx_fclk),
    .rx_data(rx_data), .rx_lock(rx_lock), .rx_virt_frame_clk(rx_vfc), .rx_block_start(rx_bs),
    .rx_chan_status(rx_cs), .rx_user_data(rx_ud), .rx_validity(rx_val), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .multipurpose_pin_out(pin_out), .multipurpose_pin_oe(pin_oe),
    .rx_enable(rx_enable), .sample_rate_converter_mute(src_mute));
  sac_rx_model #(.LEFT_W(LW), .RIGHT_W(RW)) rx (
    .tdm(tdm), .locked(locked), .bit_clk(rx_bclk), .frame_clk(rx_fclk), .data(rx_data),
    .lock(rx_lock), .vfc(rx_vfc), .bs(rx_bs), .cs(rx_cs), .ud(rx_ud), .val(rx_val));

  // 250 MHz core clock
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a wait that ran out is a failure and ends the run
  task automatic timeout_if(input logic hit);
    if (hit) begin
      failures++;
      end_sim;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one-cycle strobes; the next access never starts in the same time step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string msg);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(posedge mclk);
    check(reg_rdata, e, msg);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values, reserved bits and read-only places
  task automatic t_regs;
    rd(sac_pkg::SAC_ADDR_MODE, 16'h0001, "mode reset");
    rd(sac_pkg::SAC_ADDR_LOCK, 16'h0001, "lock");
    rd(sac_pkg::SAC_ADDR_HOT, 16'h0000, "hot reset");
    rd(sac_pkg::SAC_ADDR_ENSTAT, 16'h0001, "always on");
    rd(sac_pkg::SAC_ADDR_LOL, 16'h0000, "lol reset");
    rd(sac_pkg::SAC_ADDR_PINCTL, 16'h0000, "pinctl reset");
    rd(16'he0cd, 16'h0000, "unmapped");
    wr(sac_pkg::SAC_ADDR_PINCTL, 16'hfff8);
    rd(sac_pkg::SAC_ADDR_PINCTL, 16'h0000, "pinctl reserved");
    wr(sac_pkg::SAC_ADDR_LOCK, 16'h0000);
    rd(sac_pkg::SAC_ADDR_LOCK, 16'h0001, "lock read only");
    wr(sac_pkg::SAC_ADDR_MODE, 16'hfffd);
    rd(sac_pkg::SAC_ADDR_MODE, 16'h0001, "mode reserved");
  endtask
  // group enables against gpio passthrough
  task automatic pins(input logic [15:0] ctl, input logic [11:0] own);
    wr(sac_pkg::SAC_ADDR_PINCTL, ctl);
    tick(4);
    check(pin_oe, own | (gpio_oe & ~own), "pin enables");
    check(pin_out & ~own, gpio_out & ~own, "gpio passthrough");
  endtask
  task automatic t_pins;
    pins(16'h0000, 12'h000);
    pins(16'h0001, 12'he00);
    pins(16'h0002, 12'h1f0);
    pins(16'h0003, 12'hff0);
    wr(sac_pkg::SAC_ADDR_MODE, 16'h0000);
    pins(16'h0003, 12'h000);
    rd(sac_pkg::SAC_ADDR_ENSTAT, 16'h0000, "mode off");
  endtask
  // hot enable: set, cleared on lock loss, restored by software
  task automatic t_hot;
    wr(sac_pkg::SAC_ADDR_MODE, 16'h0002);
    pins(16'h0003, 12'h000);
    wr(sac_pkg::SAC_ADDR_HOT, 16'hffff);
    rd(sac_pkg::SAC_ADDR_HOT, 16'h0001, "hot set");
    rd(sac_pkg::SAC_ADDR_ENSTAT, 16'h0001, "hot on");
    check(pin_oe, 12'hfff, "hot pins");
    // model holds block start 1, status 0, user 1, validity 0 on pins 7..4
    check(pin_out[7:4], 4'ha, "group two levels");
    locked <= 1'h0;
    tick(12);
    rd(sac_pkg::SAC_ADDR_LOCK, 16'h0000, "lock lost");
    rd(sac_pkg::SAC_ADDR_HOT, 16'h0000, "hot cleared");
    rd(sac_pkg::SAC_ADDR_ENSTAT, 16'h0000, "off on loss");
    locked <= 1'h1;
    tick(12);
    rd(sac_pkg::SAC_ADDR_ENSTAT, 16'h0000, "stays off");
    wr(sac_pkg::SAC_ADDR_HOT, 16'h0001); // software restores after recovery
    rd(sac_pkg::SAC_ADDR_ENSTAT, 16'h0001, "restored");
  endtask
  // scan more than one i2s frame for any high frame sync or data
  task automatic scan(output logic f, output logic s);
    f = 1'h0;
    s = 1'h0;
    repeat (3000) begin
      @(posedge mclk);
      f |= pin_out[11];
      s |= pin_out[9];
    end
  endtask
  task automatic t_lol;
    logic f, s;
    wr(sac_pkg::SAC_ADDR_MODE, 16'h0001);
    locked <= 1'h0;
    tick(12);
    check(rx_enable, 1'h0, "rx off");
    check(src_mute, 1'h1, "src muted");
    scan(f, s);
    check(f, 1'h0, "sync stopped");
    wr(sac_pkg::SAC_ADDR_LOL, 16'h0001);
    tick(4);
    check({rx_enable, src_mute}, 2'h2, "rx kept");
    scan(f, s);
    check({f, s}, 2'h2, "sync on, data zero");
    locked <= 1'h1;
    wr(sac_pkg::SAC_ADDR_LOL, 16'h0000); // back to the default once recovery is over
    tick(12);
    check({rx_enable, src_mute}, 2'h2, "relocked");
  endtask
  // i2s: group one pins mirror the receiver a few cycles late
  task automatic t_i2s;
    int c;
    logic fc;
    for (int k = 0; k < 2; k++) begin
      fc = rx_fclk;
      for (c = 0; c < 4000 && rx_fclk === fc; c++) @(posedge mclk);
      timeout_if(c == 4000);
      tick(8);
      check(pin_out[11:9], {rx_fclk, rx_bclk, rx_data}, "i2s mirror");
    end
  endtask
  // tdm: grab a whole frame mid bit and compare every slot
  task automatic t_tdm;
    logic [255:0] fr;
    logic [31:0] e;
    logic p10;
    int c, fs, n, k;
    wr(sac_pkg::SAC_ADDR_PINCTL, 16'h0005);
    tdm <= 1'h1;
    fs = 0;
    n = 0;
    k = 99;
    p10 = 1'h1;
    for (c = 0; c < 70000 && n < 256; c++) begin
      @(posedge mclk);
      k++;
      if (pin_out[10] && !p10) begin
        k = 0;
        if (pin_out[11]) fs++;
      end
      p10 = pin_out[10];
      if (k == 10 && fs >= 4) begin
        fr[255 - n] = pin_out[9];
        n++;
      end
    end
    timeout_if(n < 256);
    for (int s = 0; s < 8; s++) begin
      case (s)
        0: e = LW;
        1: e = 32'h9800_0000;
        4: e = RW;
        default: e = 32'h0000_0000;
      endcase
      check(fr[255 - 32 * s -: 32], e, "tdm slot");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset = 1'h1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    tdm = 1'h0;
    locked = 1'h1;
    gpio_out = 12'ha5a;
    gpio_oe = 12'h00f;
    failures = 0;
    samples_checked = 0;
    tick(16);
    reset <= 1'h0;
    tick(8);
    t_regs;
    t_pins;
    t_hot;
    t_lol;
    t_i2s;
    t_tdm;
    end_sim;
  end
endmodule
